// file: bsc_decoder.sv
// Decoder and executor for bit clear/set, bit test-and-skip and call
`timescale 1ns/1ps

module bsc_decoder import bsc_pkg::*; (
   input wire logic sys_clk, // Core instruction clock
   input wire logic rstn, // Synchronous reset, active low
   input wire logic instr_valid, // Fetch stage offers a word
   input wire logic [INSTR_W-1:0] instr, // Instruction word
   input wire logic [PC_W-1:0] instr_pc, // Address of that word
   input wire logic [DATA_W-1:0] pc_high_latch, // Program counter high latch
   input wire logic [DATA_W-1:0] rd_data, // File data at rd_addr
   output logic instr_ready, // Block can take a word
   output logic [FADDR_W-1:0] rd_addr, // File read address
   output logic wr_en, // File write strobe
   output logic [FADDR_W-1:0] wr_addr, // File write address
   output logic [DATA_W-1:0] wr_data, // File write data
   output logic discard, // Fetched word dropped as no-op
   output logic pc_load, // Load program counter
   output logic [PC_W-1:0] pc_target, // New program counter
   output logic push_en, // Push onto return stack
   output logic [PC_W-1:0] stack_top // Value pushed
);
   bsc_state_type state_q, state_d;
   logic ready_q;
   logic squash_q;
   logic [1:0] subop_q;
   logic [BSEL_W-1:0] bsel_q;
   logic [FADDR_W-1:0] rd_addr_q, wr_addr_q;
   logic [DATA_W-1:0] wr_data_q;
   logic wr_en_q, discard_q, pc_load_q, push_q;
   logic [PC_W-1:0] pc_target_q, stack_top_q;

   // Decode of the offered word
   wire take = instr_valid && ready_q && (state_q == ST_IDLE);
   wire is_bitop = instr[INSTR_W-1:GROUP_LSB] == GROUP_BIT;
   wire is_call = instr[INSTR_W-1:CALL_LSB] == CALL_CODE;
   wire take_drop = take && squash_q;
   wire take_bit = take && !squash_q && is_bitop;
   wire take_call = take && !squash_q && is_call;
   wire [1:0] subop = instr[GROUP_LSB-1:SUBOP_LSB];
   wire [BSEL_W-1:0] bsel = instr[SUBOP_LSB-1:BSEL_LSB];
   wire [FADDR_W-1:0] faddr = instr[BSEL_LSB-1:FADDR_LSB];
   wire [PC_W-1:0] call_dest =
      {pc_high_latch[LATCH_HI:LATCH_LO], instr[KIMM_W-1:0]};
   wire [PC_W-1:0] ret_addr = instr_pc + PC_ONE;

   // Execute-stage decode on the latched operation
   wire in_exec = state_q == ST_EXEC;
   wire [DATA_W-1:0] mod_byte;
   wire bit_now;
   wire do_write = in_exec && !subop_q[1];
   wire do_skip = in_exec && subop_q[1] && (bit_now == subop_q[0]);

   // Forces one bit, the other seven return as read
   bsc_bitmod #(.WIDTH(DATA_W)) u_bitmod (
      .byte_in(rd_data),
      .sel(bsel_q),
      .new_val(subop_q[0]),
      .byte_out(mod_byte),
      .bit_val(bit_now)
   );

   // Next state; a bit op spends one slot reading before it writes
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (take_bit) begin
               state_d = ST_EXEC;
            end
         end
         ST_EXEC: begin
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // Control: state, handshake and the discard flag
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         state_q <= ST_IDLE;
         ready_q <= 1'b0;
         squash_q <= 1'b0;
      end else begin
         state_q <= state_d;
         ready_q <= (state_d == ST_IDLE);
         // Set wins: a skip cannot coincide with a drop, so no loss
         squash_q <= (squash_q && !take_drop) || do_skip || take_call;
      end
   end

   // Latched operands of a bit op
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         subop_q <= SUB_CLEAR;
         bsel_q <= '0;
         rd_addr_q <= FADDR_RST;
      end else if (take_bit) begin
         subop_q <= subop;
         bsel_q <= bsel;
         rd_addr_q <= faddr;
      end
   end

   // Register file write; no status flag exists on this path at all
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         wr_en_q <= 1'b0;
         wr_addr_q <= FADDR_RST;
         wr_data_q <= DATA_RST;
      end else begin
         wr_en_q <= do_write;
         if (do_write) begin
            wr_addr_q <= rd_addr_q;
            wr_data_q <= mod_byte;
         end
      end
   end

   // Call side: stack push and program counter redirect, plus the discard pulse
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         push_q <= 1'b0;
         pc_load_q <= 1'b0;
         discard_q <= 1'b0;
         stack_top_q <= PC_RST;
         pc_target_q <= PC_RST;
      end else begin
         push_q <= take_call;
         pc_load_q <= take_call;
         discard_q <= take_drop;
         if (take_call) begin
            stack_top_q <= ret_addr;
            pc_target_q <= call_dest;
         end
      end
   end

   // Every output straight from a flip-flop
   assign instr_ready = ready_q;
   assign rd_addr = rd_addr_q;
   assign wr_en = wr_en_q;
   assign wr_addr = wr_addr_q;
   assign wr_data = wr_data_q;
   assign discard = discard_q;
   assign pc_load = pc_load_q;
   assign pc_target = pc_target_q;
   assign push_en = push_q;
   assign stack_top = stack_top_q;

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   sequence s_bit_taken(logic [1:0] code);
      take_bit && subop == code ##1 in_exec;
   endsequence

   sequence s_call_taken;
      take_call;
   endsequence

   a_clear_bit: assert property (
      s_bit_taken(SUB_CLEAR) |=> wr_en_q && !wr_data_q[$past(bsel_q)]
   ) else $error("bit clear did not zero the bit");

   a_set_bit: assert property (
      s_bit_taken(SUB_SET) |=> wr_en_q && wr_data_q[$past(bsel_q)]
   ) else $error("bit set did not raise the bit");

   a_skip_zero: assert property (
      in_exec && subop_q == SUB_TEST_ZERO |=>
         !wr_en_q && (squash_q == !$past(rd_data[bsel_q]))
   ) else $error("skip on zero decided wrongly");

   a_skip_one: assert property (
      in_exec && subop_q == SUB_TEST_ONE |=>
         !wr_en_q && (squash_q == $past(rd_data[bsel_q]))
   ) else $error("skip on one decided wrongly");

   a_skip_discard: assert property (
      take_drop |=> discard_q && !wr_en_q && !push_q && !pc_load_q
         && !squash_q && state_q == ST_IDLE
   ) else $error("discarded word was not a no-op");

   a_field_decode: assert property (
      take_bit |=> rd_addr_q == $past(instr[6:0])
         && bsel_q == $past(instr[9:7]) ##1 !in_exec
   ) else $error("bit op fields latched wrongly");

   a_call_push: assert property (
      s_call_taken |=> push_q && stack_top_q == $past(instr_pc) + PC_ONE
   ) else $error("call pushed the wrong return address");

   a_call_target: assert property (
      s_call_taken |=> pc_load_q
         && pc_target_q[10:0] == $past(instr[10:0])
         && pc_target_q[12:11] == $past(pc_high_latch[4:3])
   ) else $error("call target formed wrongly");

   a_call_two_slot: assert property (
      s_call_taken |=> squash_q ##1 (squash_q || discard_q)
   ) else $error("call did not discard the next fetch");

   a_rmw_keep: assert property (
      do_write |=> wr_en_q && ((wr_data_q ^ $past(rd_data))
         & ~(8'h01 << $past(bsel_q))) == 8'h00
   ) else $error("write back changed an unselected bit");
endmodule : bsc_decoder

// file: bsc_bitmod.sv
// Shared constants and the single-bit modify unit of the decoder
`timescale 1ns/1ps

package bsc_pkg;
   // Instruction word layout
   localparam int INSTR_W = 14;
   localparam int PC_W = 13;
   localparam int FADDR_W = 7;
   localparam int BSEL_W = 3;
   localparam int DATA_W = 8;
   localparam int KIMM_W = 11;
   localparam int FADDR_LSB = 0;
   localparam int BSEL_LSB = 7;
   localparam int SUBOP_LSB = 10;
   localparam int GROUP_LSB = 12;
   localparam int CALL_LSB = 11;
   localparam int LATCH_LO = 3;
   localparam int LATCH_HI = 4;
   // Opcode encodings
   localparam logic [1:0] GROUP_BIT = 2'h1;
   localparam logic [2:0] CALL_CODE = 3'h4;
   localparam logic [1:0] SUB_CLEAR = 2'h0;
   localparam logic [1:0] SUB_SET = 2'h1;
   localparam logic [1:0] SUB_TEST_ZERO = 2'h2;
   localparam logic [1:0] SUB_TEST_ONE = 2'h3;
   // Reset values and the program counter increment
   localparam logic [PC_W-1:0] PC_RST = 13'h0000;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
   localparam logic [FADDR_W-1:0] FADDR_RST = 7'h00;
   localparam logic [PC_W-1:0] PC_ONE = 13'h0001;

   // Controller states, one-hot
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_EXEC = 2'b10
   } bsc_state_type;
endpackage : bsc_pkg

module bsc_bitmod import bsc_pkg::*; #(
   parameter int WIDTH = DATA_W
) (
   input wire logic [WIDTH-1:0] byte_in, // Byte as read
   input wire logic [BSEL_W-1:0] sel, // Bit position
   input wire logic new_val, // Value for the selected bit
   output logic [WIDTH-1:0] byte_out, // Byte to write back
   output logic bit_val // Selected bit as read
);
   // Only the selected lane changes; the rest pass through untouched
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_lane
         assign byte_out[i] = (sel == BSEL_W'(i)) ? new_val : byte_in[i];
      end
   endgenerate

   assign bit_val = byte_in[sel];
endmodule : bsc_bitmod

// file: bsc_regfile_model.sv
// Register file model that sits behind the decoder's file ports
`timescale 1ns/1ps

module bsc_regfile_model (
   input wire logic sys_clk, // Core clock
   input wire logic [6:0] rd_addr, // Read address
   output logic [7:0] rd_data, // Read data, combinational
   input wire logic wr_en, // Write strobe
   input wire logic [6:0] wr_addr, // Write address
   input wire logic [7:0] wr_data // Write data
);
   logic [7:0] mem [128];
   // Read has no latency, as the decoder samples it in its read slot
   assign rd_data = mem[rd_addr];
   // Write lands only on a strobe edge
   always @(posedge sys_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end
endmodule : bsc_regfile_model

// file: tb_bsc_decoder.sv
// Self-checking bench for the bit op, skip and call decoder
`timescale 1ns/1ps

module tb_bsc_decoder import bsc_pkg::*; ();
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic instr_valid = 1'b0;
   logic [13:0] instr = 14'h0000;
   logic [12:0] instr_pc = 13'h0000;
   logic [7:0] pc_high_latch = 8'h00;
   logic [7:0] rd_data, wr_data;
   logic [6:0] rd_addr, wr_addr;
   logic instr_ready, wr_en, discard, pc_load, push_en;
   logic [12:0] pc_target, stack_top, seen_top, seen_tgt;
   logic [6:0] seen_wa;
   int bad_count = 0;
   int cmp_count = 0;
   int n_wr = 0;
   int n_dis = 0;
   int n_push = 0;
   int n_load = 0;

   always #20 sys_clk = ~sys_clk;

   bsc_decoder DUT (.sys_clk(sys_clk), .rstn(rstn),
      .instr_valid(instr_valid), .instr(instr), .instr_pc(instr_pc),
      .pc_high_latch(pc_high_latch), .rd_data(rd_data),
      .instr_ready(instr_ready), .rd_addr(rd_addr), .wr_en(wr_en),
      .wr_addr(wr_addr), .wr_data(wr_data), .discard(discard),
      .pc_load(pc_load), .pc_target(pc_target), .push_en(push_en),
      .stack_top(stack_top));

   bsc_regfile_model M (.sys_clk(sys_clk), .rd_addr(rd_addr),
      .rd_data(rd_data), .wr_en(wr_en), .wr_addr(wr_addr),
      .wr_data(wr_data));

   // Pulses are counted so a double or missing strobe shows up
   always @(posedge sys_clk) begin
      if (wr_en === 1'b1) begin
         n_wr++;
         seen_wa = wr_addr;
      end
      if (discard === 1'b1) n_dis++;
      if (push_en === 1'b1) begin
         n_push++;
         seen_top = stack_top;
      end
      if (pc_load === 1'b1) begin
         n_load++;
         seen_tgt = pc_target;
      end
   end

   task close_out;
      if (bad_count == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : close_out

   task chk(input logic [12:0] seen, input logic [12:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Offers the word on the next rising edge and holds it one edge past ready, so an early offer is still taken
   task issue(input logic [13:0] w, input logic [12:0] p);
      @(posedge sys_clk);
      instr_valid <= 1'b1;
      instr <= w;
      instr_pc <= p;
      @(negedge sys_clk);
      repeat (20) if (instr_ready !== 1'b1) @(negedge sys_clk);
      @(posedge sys_clk);
      instr_valid <= 1'b0;
   endtask : issue

   task bitop(input logic [1:0] sub, input logic [6:0] f,
      input logic [2:0] b, input logic [7:0] init, input logic [7:0] exp);
      int w0;
      w0 = n_wr;
      M.mem[f] = init;
      issue({GROUP_BIT, sub, b, f}, 13'h0000);
      #1;
      chk(13'(instr_ready), 13'h0000);
      repeat (3) @(posedge sys_clk);
      #1;
      chk(13'(M.mem[f]), 13'(exp));
      chk(13'(n_wr - w0), 13'h0001);
      chk(13'(seen_wa), 13'(f));
      chk(13'(rd_addr), 13'(f));
   endtask : bitop

   // The follower sets bit 0 of 0x10 only if it is not skipped
   task tst(input logic [1:0] sub, input logic [6:0] f,
      input logic [2:0] b, input logic [7:0] init, input logic skip);
      int d0;
      d0 = n_dis;
      M.mem[f] = init;
      M.mem[7'h10] = 8'h00;
      issue({GROUP_BIT, sub, b, f}, 13'h0010);
      issue({GROUP_BIT, SUB_SET, 3'h0, 7'h10}, 13'h0011);
      repeat (3) @(posedge sys_clk);
      #1;
      chk(13'(M.mem[7'h10]), skip ? 13'h0000 : 13'h0001);
      chk(13'(n_dis - d0), 13'(skip));
      chk(13'(M.mem[f]), 13'(init));
   endtask : tst

   task call(input logic [10:0] k, input logic [7:0] lat,
      input logic [12:0] p);
      int d0;
      int p0;
      int l0;
      d0 = n_dis;
      p0 = n_push;
      l0 = n_load;
      M.mem[7'h11] = 8'h00;
      @(posedge sys_clk);
      pc_high_latch <= lat;
      issue({CALL_CODE, k}, p);
      issue({GROUP_BIT, SUB_SET, 3'h1, 7'h11}, p + 13'h0001);
      repeat (3) @(posedge sys_clk);
      #1;
      chk(seen_top, p + 13'h0001);
      chk(13'(n_push - p0), 13'h0001);
      chk(seen_tgt, {lat[4:3], k});
      chk(13'(n_load - l0), 13'h0001);
      chk(13'(M.mem[7'h11]), 13'h0000);
      chk(13'(n_dis - d0), 13'h0001);
   endtask : call

   // Words outside the four are taken and leave no trace on any port
   task other(input logic [13:0] w);
      int s0;
      s0 = n_wr + n_dis + n_push + n_load;
      issue(w, 13'h0020);
      repeat (3) @(posedge sys_clk);
      #1;
      chk(13'(n_wr + n_dis + n_push + n_load - s0), 13'h0000);
      chk(13'(instr_ready), 13'h0001);
   endtask : other

   // Main sequence; edges of field ranges are used on purpose
   initial begin
      repeat (12) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (2) @(posedge sys_clk);
      bitop(SUB_SET, 7'h05, 3'h3, 8'h41, 8'h49);
      bitop(SUB_CLEAR, 7'h7f, 3'h7, 8'hc7, 8'h47);
      bitop(SUB_SET, 7'h00, 3'h7, 8'h0a, 8'h8a);
      bitop(SUB_CLEAR, 7'h40, 3'h0, 8'hff, 8'hfe);
      tst(SUB_TEST_ZERO, 7'h22, 3'h2, 8'hfb, 1'b1);
      tst(SUB_TEST_ZERO, 7'h22, 3'h2, 8'h04, 1'b0);
      tst(SUB_TEST_ONE, 7'h7f, 3'h6, 8'h40, 1'b1);
      tst(SUB_TEST_ONE, 7'h7f, 3'h6, 8'hbf, 1'b0);
      call(11'h5a5, 8'h18, 13'h07ff);
      call(11'h7ff, 8'he7, 13'h1fff);
      other(14'h0795);
      other(14'h2c00);
      close_out();
   end

   // Whole run needs well under a thousand cycles
   initial begin
      #200000;
      bad_count++;
      close_out();
   end
endmodule : tb_bsc_decoder
